// [core/fsflc_pkg.sv]
// Purpose: Shared constants of the frame, sync and FIFO level control bank
// Assumes: Byte-wide registers on an 8-bit internal register port
// Notes:   Offsets, field positions and reset values live here; the assertions and bench repeat them as literals
package fsflc_pkg;

    // Register offsets
    localparam logic [7:0] FSFLC_ADDR_IRQ_SETUP  = 8'h20;
    localparam logic [7:0] FSFLC_ADDR_ALIGN_CTRL = 8'h21;
    localparam logic [7:0] FSFLC_ADDR_FRAME_CTRL = 8'h22;
    localparam logic [7:0] FSFLC_ADDR_SEP_REQ    = 8'h23;
    localparam logic [7:0] FSFLC_ADDR_SEP_MEAS   = 8'h24;

    // Reset values
    localparam logic [7:0] FSFLC_RST_IRQ_SETUP   = 8'h00;
    localparam logic [7:0] FSFLC_RST_ALIGN_CTRL  = 8'h00;
    localparam logic [7:0] FSFLC_RST_FRAME_CTRL  = 8'h12;
    localparam logic [7:0] FSFLC_RST_SEP_REQ     = 8'h40;
    localparam logic [7:0] FSFLC_RST_SEP_MEAS    = 8'h00;

    // Interrupt setup encodings
    localparam logic [7:0] FSFLC_IRQ_TEST_MODE   = 8'h00;
    localparam logic [7:0] FSFLC_IRQ_NORMAL_MODE = 8'h01;

    // Multichip alignment control fields
    localparam int FSFLC_ALIGN_EN_BIT    = 0;
    localparam int FSFLC_ALIGN_EDGE_BIT  = 1;
    localparam logic [7:0] FSFLC_ALIGN_MASK = 8'h03;

    // Frame pulse reset control fields
    localparam int FSFLC_FRAME_TGT_LSB   = 0;
    localparam int FSFLC_FRAME_TGT_MSB   = 1;
    localparam int FSFLC_FRAME_CONT_BIT  = 2;
    localparam int FSFLC_FRAME_RETRIG_BIT = 3;
    localparam int FSFLC_FRAME_SPARE_BIT = 4;
    localparam logic [7:0] FSFLC_FRAME_MASK = 8'h17;

    // Frame reset targets
    localparam logic [1:0] FSFLC_TGT_FIFO      = 2'h0;
    localparam logic [1:0] FSFLC_TGT_OSC       = 2'h1;
    localparam logic [1:0] FSFLC_TGT_BOTH      = 2'h2;
    localparam logic [1:0] FSFLC_TGT_NONE      = 2'h3;

    // FIFO separation fields, shared by request and measurement
    localparam int FSFLC_SEP_INT_LSB     = 4;
    localparam int FSFLC_SEP_INT_MSB     = 6;
    localparam int FSFLC_SEP_FRAC_LSB    = 0;
    localparam int FSFLC_SEP_FRAC_MSB    = 2;
    localparam logic [7:0] FSFLC_SEP_MASK = 8'h77;

endpackage

// [core/fsflc_sync_sampler.sv]
// Purpose: Samples the multichip sync clock on a chosen converter edge
// Assumes: sync_pin is asynchronous to clk
// Notes:   Both edge paths run always; the select only picks the result
`timescale 1ns/1ns
module fsflc_sync_sampler
    import fsflc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic sync_pin,
    input  wire logic edge_rise,
    input  wire logic enable,
    output logic      sync_level,
    output logic      sync_event
);

    logic fall_meta_r;
    logic fall_sync_r;
    logic rise_meta_r;
    logic rise_sync_r;
    logic prev_r;
    logic event_r;
    logic level_r;
    wire  sel_level;
    wire  event_nxt;

    // Falling-edge capture; its only reader is fall_sync_r
    always_ff @(negedge clk)
    begin
        if (!rst_n)
            fall_meta_r <= 1'b0;
        else
            fall_meta_r <= sync_pin;
    end

    // Second stages and edge history
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            fall_sync_r <= 1'b0;
            rise_meta_r <= 1'b0;
            rise_sync_r <= 1'b0;
            prev_r      <= 1'b0;
            event_r     <= 1'b0;
            level_r     <= 1'b0;
        end
        else
        begin
            fall_sync_r <= fall_meta_r;
            rise_meta_r <= sync_pin;
            rise_sync_r <= rise_meta_r;
            prev_r      <= sel_level;
            event_r     <= event_nxt;
            level_r     <= sel_level;
        end
    end

    // Edge choice: 0 falling, 1 rising
    assign sel_level  = edge_rise ? rise_sync_r : fall_sync_r;
    // Disabled sampling yields no alignment events
    assign event_nxt  = enable & sel_level & ~prev_r;
    assign sync_event = event_r;
    assign sync_level = level_r;

endmodule

// [core/fsflc_bank.sv]
// Purpose: Register bank for interrupt setup, multichip alignment,
//          frame pulse reset and FIFO pointer separation
// Assumes: Register port comes from the serial port engine on MCLK;
//          FRAME_PIN and SYNC_CLK_PIN are asynchronous pins
// Notes:   Read data is registered, one cycle after the address
//
// Summary of operation
// - Interrupt setup byte: 0x00 test mode at reset, 0x01 normal.
// - Sync enabled samples sync clock on falling edge, or rising if set.
// - One-shot mode: writing retrigger re-arms for the next valid pulse.
// - Mode bit 0: act on first valid frame pulse only, reset once.
// - Mode bit 1: act on every valid frame pulse.
// - Target field: FIFO, oscillator, both or nothing; reset value 2.
// - Integer separation bits 6..4 in input sample periods, 0 to 7.
// - Fractional separation bits 2..0 in converter clock cycles.
// - Separation resets to integer 4, fractional 0, the recommended.
// - Measured separation reads back, integer 6..4, fractional 2..0.
`timescale 1ns/1ns
module fsflc_bank
    import fsflc_pkg::*;
(
    input  wire logic       MCLK,
    input  wire logic       NRST,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    output logic      [7:0] REG_RDATA,
    input  wire logic       FRAME_PIN,
    input  wire logic       SYNC_CLK_PIN,
    input  wire logic [2:0] MEAS_INT_LEVEL,
    input  wire logic [2:0] MEAS_FRAC_LEVEL,
    output logic            IRQ_NORMAL_MODE,
    output logic      [7:0] IRQ_OPERATING_SELECT,
    output logic            SYNC_ENABLE,
    output logic            SYNC_EVENT,
    output logic            SYNC_LEVEL,
    output logic            FIFO_RESET_PULSE,
    output logic            OSC_RESET_PULSE,
    output logic            FRAME_ARMED,
    output logic      [2:0] REQ_INT_LEVEL,
    output logic      [2:0] REQ_FRAC_LEVEL
);

    logic [7:0] irq_setup_r;
    logic [7:0] align_ctrl_r;
    logic [7:0] frame_ctrl_r;
    logic [7:0] sep_req_r;
    logic [7:0] sep_meas_r;
    logic [7:0] rdata_r;
    logic       frame_meta_r;
    logic       frame_sync_r;
    logic       frame_prev_r;
    logic       armed_r;
    logic       fifo_rst_r;
    logic       osc_rst_r;

    wire        wr_irq;
    wire        wr_align;
    wire        wr_frame;
    wire        wr_sep;
    wire        retrig_wr;
    wire        frame_edge;
    wire        cont_mode;
    wire  [1:0] target;
    wire        act;
    wire        armed_nxt;
    wire        fifo_rst_nxt;
    wire        osc_rst_nxt;
    wire  [7:0] frame_wr_val;
    wire  [7:0] sep_meas_nxt;
    logic [7:0] rdata_nxt;

    // Write decode; the measured register has no write path
    assign wr_irq   = REG_WR & (REG_ADDR == FSFLC_ADDR_IRQ_SETUP);
    assign wr_align = REG_WR & (REG_ADDR == FSFLC_ADDR_ALIGN_CTRL);
    assign wr_frame = REG_WR & (REG_ADDR == FSFLC_ADDR_FRAME_CTRL);
    assign wr_sep   = REG_WR & (REG_ADDR == FSFLC_ADDR_SEP_REQ);
    // Retrigger acts only in one-shot mode, as written
    assign retrig_wr = wr_frame & REG_WDATA[FSFLC_FRAME_RETRIG_BIT]
                     & ~REG_WDATA[FSFLC_FRAME_CONT_BIT];
    // Retrigger bit is a command; it is not kept, so it reads zero
    assign frame_wr_val = REG_WDATA & FSFLC_FRAME_MASK;

    // Programmable registers; writes land at the edge, so the new value
    // governs only pulses seen after it
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            irq_setup_r  <= FSFLC_RST_IRQ_SETUP;
            align_ctrl_r <= FSFLC_RST_ALIGN_CTRL;
            frame_ctrl_r <= FSFLC_RST_FRAME_CTRL;
            sep_req_r    <= FSFLC_RST_SEP_REQ;
        end
        else
        begin
            if (wr_irq)
                irq_setup_r <= REG_WDATA;
            if (wr_align)
                align_ctrl_r <= REG_WDATA & FSFLC_ALIGN_MASK;
            if (wr_frame)
                frame_ctrl_r <= frame_wr_val;
            if (wr_sep)
                sep_req_r <= REG_WDATA & FSFLC_SEP_MASK;
        end
    end

    // Frame pin synchroniser and rising-edge detection
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            frame_meta_r <= 1'b0;
            frame_sync_r <= 1'b0;
            frame_prev_r <= 1'b0;
        end
        else
        begin
            frame_meta_r <= FRAME_PIN;
            frame_sync_r <= frame_meta_r;
            frame_prev_r <= frame_sync_r;
        end
    end

    assign frame_edge = frame_sync_r & ~frame_prev_r;
    assign cont_mode  = frame_ctrl_r[FSFLC_FRAME_CONT_BIT];
    assign target     = frame_ctrl_r[FSFLC_FRAME_TGT_MSB:FSFLC_FRAME_TGT_LSB];

    // Continuous mode acts on every pulse, one-shot only while armed
    assign act = frame_edge & (cont_mode | armed_r);
    // Re-arm beats the consuming pulse in the same cycle
    assign armed_nxt = retrig_wr ? 1'b1
                     : (act & ~cont_mode) ? 1'b0
                     : armed_r;

    // Target decode of a valid pulse
    assign fifo_rst_nxt = act & ((target == FSFLC_TGT_FIFO)
                               | (target == FSFLC_TGT_BOTH));
    assign osc_rst_nxt  = act & ((target == FSFLC_TGT_OSC)
                               | (target == FSFLC_TGT_BOTH));

    // Arm state and one-cycle reset pulses
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            armed_r    <= 1'b1;
            fifo_rst_r <= 1'b0;
            osc_rst_r  <= 1'b0;
        end
        else
        begin
            armed_r    <= armed_nxt;
            fifo_rst_r <= fifo_rst_nxt;
            osc_rst_r  <= osc_rst_nxt;
        end
    end

    // Measured separation, refreshed every cycle from the FIFO logic
    assign sep_meas_nxt = {1'b0, MEAS_INT_LEVEL, 1'b0, MEAS_FRAC_LEVEL};

    always_ff @(posedge MCLK)
    begin
        if (!NRST)
            sep_meas_r <= FSFLC_RST_SEP_MEAS;
        else
            sep_meas_r <= sep_meas_nxt;
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        case (REG_ADDR)
            FSFLC_ADDR_IRQ_SETUP:  rdata_nxt = irq_setup_r;
            FSFLC_ADDR_ALIGN_CTRL: rdata_nxt = align_ctrl_r;
            FSFLC_ADDR_FRAME_CTRL: rdata_nxt = frame_ctrl_r;
            FSFLC_ADDR_SEP_REQ:    rdata_nxt = sep_req_r;
            FSFLC_ADDR_SEP_MEAS:   rdata_nxt = sep_meas_r;
            default:               rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (!NRST)
            rdata_r <= 8'h00;
        else
            rdata_r <= rdata_nxt;
    end

    // Sync clock sampling on the selected converter edge
    fsflc_sync_sampler u_sync
    (
        .clk        (MCLK),
        .rst_n      (NRST),
        .sync_pin   (SYNC_CLK_PIN),
        .edge_rise  (align_ctrl_r[FSFLC_ALIGN_EDGE_BIT]),
        .enable     (align_ctrl_r[FSFLC_ALIGN_EN_BIT]),
        .sync_level (SYNC_LEVEL),
        .sync_event (SYNC_EVENT)
    );

    // Outputs; all from registers
    assign REG_RDATA            = rdata_r;
    assign IRQ_OPERATING_SELECT = irq_setup_r;
    // Anything other than the normal code is treated as test mode
    assign IRQ_NORMAL_MODE = (irq_setup_r == FSFLC_IRQ_NORMAL_MODE);
    assign SYNC_ENABLE          = align_ctrl_r[FSFLC_ALIGN_EN_BIT];
    assign FIFO_RESET_PULSE     = fifo_rst_r;
    assign OSC_RESET_PULSE      = osc_rst_r;
    assign FRAME_ARMED          = armed_r;
    // Fraction is passed as written; range is the host's duty
    assign REQ_INT_LEVEL  =
        sep_req_r[FSFLC_SEP_INT_MSB:FSFLC_SEP_INT_LSB];
    assign REQ_FRAC_LEVEL =
        sep_req_r[FSFLC_SEP_FRAC_MSB:FSFLC_SEP_FRAC_LSB];

endmodule

// [verification/fsflc_bank_asserts.sv]
// Purpose: Port assertions for the control register bank
// Assumes: One MCLK domain, NRST synchronous active low
// Notes:   Bound to every bank instance below
`timescale 1ns/1ns
module fsflc_bank_asserts
    import fsflc_pkg::*;
(
    input wire logic       MCLK,
    input wire logic       NRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic [7:0] REG_RDATA,
    input wire logic       FRAME_PIN,
    input wire logic [2:0] MEAS_INT_LEVEL,
    input wire logic [2:0] MEAS_FRAC_LEVEL,
    input wire logic       IRQ_NORMAL_MODE,
    input wire logic [7:0] IRQ_OPERATING_SELECT,
    input wire logic       SYNC_ENABLE,
    input wire logic       SYNC_EVENT,
    input wire logic       FIFO_RESET_PULSE,
    input wire logic       OSC_RESET_PULSE,
    input wire logic       FRAME_ARMED,
    input wire logic [2:0] REQ_INT_LEVEL,
    input wire logic [2:0] REQ_FRAC_LEVEL
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);
    chk_irq_decode: assert property (
        IRQ_NORMAL_MODE == (IRQ_OPERATING_SELECT == 8'h01))
        else $error("irq mode flag disagrees with setup byte");
    chk_sync_enable: assert property (
        REG_WR && REG_ADDR == 8'h21 |=> SYNC_ENABLE == $past(REG_WDATA[0]))
        else $error("sync enable did not follow write");
    chk_sep_request: assert property (
        REG_WR && REG_ADDR == 8'h23 |=> {REQ_INT_LEVEL, REQ_FRAC_LEVEL}
        == {$past(REG_WDATA[6:4]), $past(REG_WDATA[2:0])})
        else $error("separation request fields wrong");
    chk_pulse_cause: assert property (
        FIFO_RESET_PULSE || OSC_RESET_PULSE |-> $past(FRAME_PIN, 3))
        else $error("reset pulse without frame pulse");
    // Reset itself is the antecedent, so no disable here
    chk_reset_state: assert property (disable iff (1'b0)
        !NRST |=> REQ_INT_LEVEL == 3'h4 && REQ_FRAC_LEVEL == 3'h0
        && FRAME_ARMED && IRQ_OPERATING_SELECT == 8'h00)
        else $error("reset state wrong");
    chk_meas_readback: assert property (
        $past(REG_ADDR) == 8'h24 && $past(NRST) && $past(NRST, 2)
        |-> REG_RDATA ==
        {1'b0, $past(MEAS_INT_LEVEL, 2), 1'b0, $past(MEAS_FRAC_LEVEL, 2)})
        else $error("measured separation readback wrong");
    chk_retrig_arm: assert property (
        REG_WR && REG_ADDR == 8'h22 && REG_WDATA[3:2] == 2'b10
        |=> FRAME_ARMED)
        else $error("retrigger did not arm");
    chk_sync_quiet: assert property (
        !SYNC_ENABLE [*5] |-> !SYNC_EVENT)
        else $error("sync event while disabled");
endmodule
bind fsflc_bank fsflc_bank_asserts u_chk (.*);

// [verification/fsflc_host.sv]
// Purpose: Host model driving the bank's register port
// Assumes: Changes land 2 ns after a rising MCLK edge
// Notes:   Write data is inverted once released
`timescale 1ns/1ns
module fsflc_host #(
    parameter int INTERP = 4
) (
    input  wire logic       MCLK,
    output logic      [7:0] REG_ADDR,
    output logic      [7:0] REG_WDATA,
    output logic            REG_WR
);
    // Idle port at time zero
    initial
    begin
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REG_WR = 1'b0;
    end
    // One-cycle write; fraction kept inside the interpolation range
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h23 && d[2:0] > 3'(INTERP - 1))
            d[2:0] = 3'(INTERP - 1);
        @(posedge MCLK);
        #2 REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(posedge MCLK);
        #2 REG_WR = 1'b0;
        REG_WDATA = ~d;
    endtask
    // Address held until the next call
    task automatic set_addr(input logic [7:0] a);
        @(posedge MCLK);
        #2 REG_ADDR = a;
    endtask
endmodule

// [verification/frame_sync_fifo_level_control_tb.sv]
// Purpose: Self-checking bench for the control register bank
// Assumes: Host model owns the register port
// Notes:   Reads and frame pulses are checked through queues
`timescale 1ns/1ns
module frame_sync_fifo_level_control_tb;
    logic       mclk;
    logic       nrst;
    logic       frame_pin;
    logic       sync_pin;
    logic [2:0] meas_int;
    logic [2:0] meas_frac;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic [7:0] reg_rdata;
    logic       fifo_p;
    logic       osc_p;
    logic       rd_due;
    logic       irq_norm;
    logic       sync_ev;
    logic       sync_lvl;
    logic       armed;
    logic [2:0] req_int;
    logic [2:0] req_frac;
    int         sync_cnt;
    logic [7:0] d;
    logic [7:0] rq[$];
    logic [1:0] pq[$];
    int         err_count;
    int         checked;
    int         t;

    fsflc_host host (.MCLK(mclk), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr));
    fsflc_bank dut (.MCLK(mclk), .NRST(nrst), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RDATA(reg_rdata),
        .FRAME_PIN(frame_pin), .SYNC_CLK_PIN(sync_pin),
        .MEAS_INT_LEVEL(meas_int), .MEAS_FRAC_LEVEL(meas_frac),
        .IRQ_NORMAL_MODE(irq_norm), .IRQ_OPERATING_SELECT(),
        .SYNC_ENABLE(), .SYNC_EVENT(sync_ev), .SYNC_LEVEL(sync_lvl),
        .FIFO_RESET_PULSE(fifo_p), .OSC_RESET_PULSE(osc_p),
        .FRAME_ARMED(armed), .REQ_INT_LEVEL(req_int),
        .REQ_FRAC_LEVEL(req_frac));

    // 25 MHz clock
    initial
    begin
        mclk = 0;
        forever #20 mclk = ~mclk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d of %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Address held three edges so the readback path settles
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host.set_addr(a);
        rq.push_back(exp);
        repeat (3) @(posedge mclk);
        rd_due = 1;
        @(negedge mclk);
    endtask
    // Pin held high and low five cycles, beyond the two needed
    task automatic fire(input logic [1:0] exp, input bit want);
        if (want)
            pq.push_back(exp);
        @(posedge mclk);
        #2 frame_pin = 1;
        repeat (5) @(posedge mclk);
        #2 frame_pin = 0;
        repeat (5) @(posedge mclk);
        check(8'(pq.size()), 8'h00);
    endtask
    // Four pin rises; level checked just before each change, events
    // counted after the pipeline has drained
    task automatic toggles(input int exp);
        int base;
        base = sync_cnt;
        repeat (8)
        begin
            repeat (3) @(posedge mclk);
            #1 check(8'(sync_lvl), 8'(sync_pin));
            #1 sync_pin = ~sync_pin;
        end
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        check(8'(sync_cnt - base), 8'(exp));
    endtask
    // Result watchers; a pulse with nothing queued is a mismatch
    always @(negedge mclk)
        if (rd_due)
        begin
            check(reg_rdata, rq.pop_front());
            rd_due = 0;
        end
    always @(negedge mclk)
        if (fifo_p || osc_p)
            check({6'h0, fifo_p, osc_p},
                pq.size() ? {6'h0, pq.pop_front()} : 8'h00);
    // Sync events are counted, compared at the end of each burst
    always @(negedge mclk)
        if (sync_ev)
            sync_cnt++;
    initial
    begin
        #120000;
        err_count++;
        close_out();
    end
    initial
    begin
        {nrst, frame_pin, sync_pin, meas_int, meas_frac, rd_due} = '0;
        err_count = 0;
        checked = 0;
        sync_cnt = 0;
        void'($urandom(11));
        repeat (4) @(posedge mclk);
        #2 nrst = 1;
        rd(8'h20, 8'h00);
        check(8'(irq_norm), 8'h00);
        rd(8'h22, 8'h12);
        rd(8'h23, 8'h40);
        rd(8'h30, 8'h00);
        host.wr(8'h20, 8'h01);
        rd(8'h20, 8'h01);
        check(8'(irq_norm), 8'h01);
        toggles(0);
        host.wr(8'h21, 8'hFD);
        rd(8'h21, 8'h01);
        toggles(4);
        host.wr(8'h21, 8'h03);
        toggles(4);
        fire(2'b11, 1);
        fire(2'b11, 0);
        check(8'(armed), 8'h00);
        host.wr(8'h22, 8'h1A);
        fire(2'b11, 1);
        for (t = 0; t < 4; t++)
        begin
            host.wr(8'h22, 8'h14 | 8'(t));
            repeat (2) fire({t == 0 || t == 2, t == 1 || t == 2}, t != 3);
        end
        // Retrigger together with continuous mode must not arm
        host.wr(8'h22, 8'h0E);
        check(8'(armed), 8'h00);
        host.wr(8'h22, 8'h02);
        fire(2'b10, 0);
        for (t = 0; t < 6; t++)
        begin
            d = {1'b0, 3'($urandom), 1'b0, 3'($urandom_range(3, 0))};
            host.wr(8'h23, d | 8'h88);
            rd(8'h23, d);
            check({1'b0, req_int, 1'b0, req_frac}, d);
            @(posedge mclk);
            #2 meas_int = 3'($urandom);
            meas_frac = 3'($urandom);
            host.wr(8'h24, 8'hFF);
            rd(8'h24, {1'b0, meas_int, 1'b0, meas_frac});
        end
        // Mid-run reset
        @(posedge mclk);
        #2 nrst = 0;
        repeat (2) @(posedge mclk);
        #2 nrst = 1;
        rd(8'h23, 8'h40);
        rd(8'h22, 8'h12);
        check(8'(armed), 8'h01);
        close_out();
    end
endmodule
